// File: verilog/sphl_port.sv
// Contract
// - Permanent mode holds CTS high always
// - Remote-local: RTS drives CTS and remote RLSD
// - Ignore mode holds CTS low always
// - Local mode: CTS follows local RTS
// - Local mode delays CTS 0/30/60/100 ms
// - DTE role disables CTS options; defaults perm
// - DTE loopback returns send data, still sends to far
// - Network loopback returns network data to far
// - Network loopback drops DSR
// - DDS code inserted in every slot byte
// - V.54 and FT1 code formats supported
// - Performance mode carries 8 kbps channel
// - Non-DDS formats send loop-up or loop-down
// - DDS requests OCU/DSU/CSU/DS0 or release
// - One port runs code sequences at once
// - DTE role offers near network loopback; far loop only suppresses its code
// - Detect only enabled, matching-format codes
// - Detect enable never blocks local loopbacks
// - Non-DDS detected loopback holds until release code; in DDS the release code sets it
// - Timed detect releases after ten minutes
// - Error rate over threshold raises alarm
// - Receive clock optionally inverted, default normal
`timescale 1ns/1ps
module sphl_port
	import sphl_pkg::*;
#(
	parameter int MS_CNT = MS_CYCLES,
	parameter int TIMEOUT_MS = DET_TIMEOUT_MS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// DTE leads
	input wire logic dteRts,
	input wire logic dteSendData,
	input wire logic portClk,
	output logic dteCts,
	output logic dteDsr,
	output logic dteRecvData,
	output logic dteRecvClk,
	// Network side
	input wire logic netRxData,
	input wire logic netRemoteRts,
	input wire logic [7:0] netRxCode,
	input wire logic netRxCodeValid,
	input wire logic errBit,
	output logic netTxData,
	output logic netRlsd,
	output logic [7:0] netTxCode,
	output logic netTxCodeValid,
	output logic perfTick,
	// Card-level arbitration between ports
	input wire logic seqGrant,
	output logic seqRequest,
	// Status
	output logic excessErrAlarm,
	output logic remoteLoopActive
);
	logic [31:0] ctrl_q, loop_q, err_q;
	logic awHave_q, wHave_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic rtsS, sdS, clkS, rxS, rrtsS;
	logic ctsL_q, clkPrev_q;
	logic [15:0] msCnt_q;
	logic msTick;
	logic [7:0] dlyMs_q;
	logic [7:0] dlyTarget;
	logic [31:0] toMs_q;
	logic remLoop_q;
	logic [3:0] sendCnt_q;
	logic [31:0] bitCnt_q, errCnt_q;
	logic [15:0] perfCnt_q;
	sphl_cts_t ctsMode;
	sphl_near_t nearSel;
	sphl_fmt_t fmt;
	sphl_cmd_t cmd;
	sphl_det_t det;
	logic dteRole, rxInv, nearDte, nearNet, farLoop;

	sphl_sync #(.W(5)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.asyncIn({dteRts, dteSendData, portClk, netRxData, netRemoteRts}),
		.syncOut({rtsS, sdS, clkS, rxS, rrtsS})
	);

	assign ctsMode = sphl_cts_t'(ctrl_q[CTRL_CTS_POS +: 2]);
	assign dteRole = ctrl_q[CTRL_ROLE_POS];
	assign rxInv = ctrl_q[CTRL_RXINV_POS];
	assign nearSel = sphl_near_t'(loop_q[LOOP_NEAR_POS +: 2]);
	assign fmt = sphl_fmt_t'(loop_q[LOOP_FMT_POS +: 2]);
	assign cmd = sphl_cmd_t'(loop_q[LOOP_CMD_POS +: 3]);
	assign det = sphl_det_t'(loop_q[LOOP_DET_POS +: 2]);

	function automatic logic [7:0] codeFor(input sphl_fmt_t f, input sphl_cmd_t c);
		case (f)
			FMT_DDS:
				case (c)
					CMD_OCU: codeFor = CODE_DDS_OCU;
					CMD_DSU: codeFor = CODE_DDS_DSU;
					CMD_CSU: codeFor = CODE_DDS_CSU;
					CMD_DS0: codeFor = CODE_DDS_DS0;
					default: codeFor = CODE_DDS_OFF;
				endcase
			FMT_V54: codeFor = (c == CMD_ON) ? CODE_V54_UP : CODE_V54_DN;
			FMT_FT1: codeFor = (c == CMD_ON) ? CODE_FT1_UP : CODE_FT1_DN;
			default: codeFor = (c == CMD_ON) ? CODE_PERF_UP : CODE_PERF_DN;
		endcase
	endfunction : codeFor

	// AXI write: address and data taken in either order
	assign s_axi_awready = !awHave_q && !s_axi_bvalid;
	assign s_axi_wready = !wHave_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHave_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (awHave_q && wHave_q)
			begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr_q == REG_CTRL || awAddr_q == REG_LOOP || awAddr_q == REG_ERR) ? 2'h0 : 2'h2;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction : merge

	// Register file; go bit self-clears when sequence is sent
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RESET;
			loop_q <= LOOP_RESET;
			err_q <= ERR_RESET;
		end
		else
		begin
			if (awHave_q && wHave_q && awAddr_q == REG_CTRL)
				ctrl_q <= merge(ctrl_q, wData_q, wStrb_q);
			if (awHave_q && wHave_q && awAddr_q == REG_LOOP)
				loop_q <= merge(loop_q, wData_q, wStrb_q);
			else if (netTxCodeValid && sendCnt_q == 4'h0)
				loop_q[LOOP_GO_POS] <= 1'b0;
			if (awHave_q && wHave_q && awAddr_q == REG_ERR)
				err_q <= merge(err_q, wData_q, wStrb_q);
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
				REG_CTRL: s_axi_rdata <= ctrl_q;
				REG_LOOP: s_axi_rdata <= loop_q;
				REG_ERR: s_axi_rdata <= err_q;
				REG_STATUS: s_axi_rdata <= {28'h0, seqRequest, remLoop_q, excessErrAlarm, dteCts};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Millisecond enable
	assign msTick = (msCnt_q == 16'(MS_CNT - 1));
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			msCnt_q <= 16'h0000;
		else
			msCnt_q <= msTick ? 16'h0000 : msCnt_q + 16'h0001;
	end

	always_comb
	begin
		case (ctrl_q[CTRL_DLY_POS +: 2])
			2'h0: dlyTarget = 8'(CTS_DLY0_MS);
			2'h1: dlyTarget = 8'(CTS_DLY1_MS);
			2'h2: dlyTarget = 8'(CTS_DLY2_MS);
			default: dlyTarget = 8'(CTS_DLY3_MS);
		endcase
	end

	// Delayed follower: RTS must hold for the delay before CTS moves
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ctsL_q <= 1'b0;
			dlyMs_q <= 8'h00;
		end
		else if (rtsS == ctsL_q)
			dlyMs_q <= 8'h00;
		else if (dlyMs_q >= dlyTarget)
		begin
			ctsL_q <= rtsS;
			dlyMs_q <= 8'h00;
		end
		else if (msTick)
			dlyMs_q <= dlyMs_q + 8'h01;
	end

	always_comb
	begin
		if (dteRole)
			dteCts = 1'b1;
		else
			case (ctsMode)
				CTS_PERM: dteCts = 1'b1;
				CTS_RLOCAL: dteCts = rtsS;
				CTS_IGNORE: dteCts = 1'b0;
				CTS_LOCAL: dteCts = ctsL_q;
				default: dteCts = 1'b1;
			endcase
	end
	assign netRlsd = (!dteRole && ctsMode == CTS_RLOCAL) ? rtsS : 1'b1;

	// Loopback data paths; local loops never gated by detect enable
	assign nearDte = (nearSel == NEAR_DTE);
	assign nearNet = (nearSel == NEAR_NET) || remLoop_q;
	assign farLoop = dteRole && loop_q[LOOP_GO_POS] && cmd == CMD_ON;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			dteRecvData <= 1'b1;
			netTxData <= 1'b1;
			dteDsr <= 1'b0;
			clkPrev_q <= 1'b0;
			dteRecvClk <= 1'b0;
		end
		else
		begin
			dteRecvData <= nearDte ? sdS : rxS;
			netTxData <= nearNet ? rxS : sdS;
			dteDsr <= !nearNet;
			clkPrev_q <= clkS;
			dteRecvClk <= clkS ^ rxInv;
		end
	end

	// Code generation, one port at a time via card grant
	assign seqRequest = loop_q[LOOP_GO_POS] && !farLoop;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sendCnt_q <= 4'h0;
			netTxCodeValid <= 1'b0;
			netTxCode <= 8'h00;
		end
		else if (seqRequest && seqGrant && clkS && !clkPrev_q)
		begin
			netTxCode <= codeFor(fmt, cmd);
			netTxCodeValid <= 1'b1;
			sendCnt_q <= (sendCnt_q == 4'(CODE_LEN - 1)) ? 4'h0 : sendCnt_q + 4'h1;
		end
		else
			netTxCodeValid <= 1'b0;
	end

	// Performance channel pulse at 8 kHz
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			perfCnt_q <= 16'h0000;
			perfTick <= 1'b0;
		end
		else
		begin
			perfTick <= (fmt == FMT_PERF) && (perfCnt_q == 16'(PERF_DIV - 1));
			perfCnt_q <= (perfCnt_q == 16'(PERF_DIV - 1)) ? 16'h0000 : perfCnt_q + 16'h0001;
		end
	end

	// Remote loop detection and timeout
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			remLoop_q <= 1'b0;
			toMs_q <= 32'h0;
		end
		else
		begin
			if (det != DET_OFF && netRxCodeValid)
			begin
				if (netRxCode == codeFor(fmt, CMD_ON) || (fmt == FMT_DDS && netRxCode == codeFor(fmt, CMD_DS0)))
				begin
					remLoop_q <= 1'b1;
					toMs_q <= 32'h0;
				end
				else if (netRxCode == codeFor(fmt, CMD_OFF))
					remLoop_q <= 1'b0;
			end
			else if (remLoop_q && det == DET_TIMED && msTick)
			begin
				if (toMs_q >= 32'(TIMEOUT_MS - 1))
					remLoop_q <= 1'b0;
				else
					toMs_q <= toMs_q + 32'h1;
			end
		end
	end
	assign remoteLoopActive = remLoop_q;

	// Error rate: nonzero err_q[3:0] enables; window of err_q[31:4] + 1 bits
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			bitCnt_q <= 32'h0;
			errCnt_q <= 32'h0;
			excessErrAlarm <= 1'b0;
		end
		else if (err_q[3:0] == 4'h0)
			excessErrAlarm <= 1'b0;
		else if (clkS && !clkPrev_q)
		begin
			if (bitCnt_q >= err_q[31:4])
			begin
				excessErrAlarm <= (errCnt_q + {31'h0, errBit}) > 32'h1;
				bitCnt_q <= 32'h0;
				errCnt_q <= 32'h0;
			end
			else
			begin
				bitCnt_q <= bitCnt_q + 32'h1;
				errCnt_q <= errCnt_q + {31'h0, errBit};
			end
		end
	end

	AST_PERM_CTS: assert property (@(posedge core_clk) disable iff (rst)
		(!dteRole && ctsMode == CTS_PERM) |-> dteCts) else $error("cts not high in perm");
	AST_IGN_CTS: assert property (@(posedge core_clk) disable iff (rst)
		(!dteRole && ctsMode == CTS_IGNORE) |-> !dteCts) else $error("cts not low in ignore");
	AST_RLOCAL: assert property (@(posedge core_clk) disable iff (rst)
		(!dteRole && ctsMode == CTS_RLOCAL) |-> (dteCts == netRlsd)) else $error("rlsd differs");
	AST_NET_DSR: assert property (@(posedge core_clk) disable iff (rst)
		(nearSel == NEAR_NET) |=> !dteDsr) else $error("dsr kept in net loop");
	AST_DTE_LOOP: assert property (@(posedge core_clk) disable iff (rst)
		(nearSel == NEAR_DTE) |=> (dteRecvData == $past(sdS))) else $error("dte loop data");
	AST_DET_OFF: assert property (@(posedge core_clk) disable iff (rst)
		(det == DET_OFF && !remLoop_q) |=> !remLoop_q) else $error("loop set while off");
	AST_LOCAL_HOLD: assert property (@(posedge core_clk) disable iff (rst)
		(!dteRole && ctsMode == CTS_LOCAL && ctsL_q != rtsS && dlyTarget != 8'h00 && dlyMs_q < dlyTarget)
		|=> $stable(ctsL_q)) else $error("cts moved early");
	AST_GRANT: assert property (@(posedge core_clk) disable iff (rst)
		netTxCodeValid |-> $past(seqGrant)) else $error("code sent without grant");
endmodule : sphl_port

// File: verilog/sphl_pkg.sv
package sphl_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LOOP = 8'h04;
	localparam logic [7:0] REG_ERR = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	// CTRL field positions
	localparam int CTRL_CTS_POS = 0;
	localparam int CTRL_DLY_POS = 2;
	localparam int CTRL_ROLE_POS = 4;
	localparam int CTRL_RXINV_POS = 5;
	// LOOP field positions
	localparam int LOOP_NEAR_POS = 0;
	localparam int LOOP_FMT_POS = 2;
	localparam int LOOP_CMD_POS = 4;
	localparam int LOOP_DET_POS = 7;
	localparam int LOOP_GO_POS = 9;
	// Reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] LOOP_RESET = 32'h0000_0100;
	localparam logic [31:0] ERR_RESET = 32'h0000_0000;
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int MS_CYCLES = CLK_HZ / 1000;
	localparam int CTS_DLY0_MS = 0;
	localparam int CTS_DLY1_MS = 30;
	localparam int CTS_DLY2_MS = 60;
	localparam int CTS_DLY3_MS = 100;
	localparam int DET_TIMEOUT_MIN = 10;
	localparam int DET_TIMEOUT_MS = DET_TIMEOUT_MIN * 60 * 1000;
	localparam int CODE_LEN = 8;
	localparam int PERF_DIV = CLK_HZ / 8000;
	// Codes: byte patterns sent in-band
	localparam logic [7:0] CODE_DDS_OCU = 8'h2A;
	localparam logic [7:0] CODE_DDS_DSU = 8'h2C;
	localparam logic [7:0] CODE_DDS_CSU = 8'h28;
	localparam logic [7:0] CODE_DDS_DS0 = 8'h3E;
	localparam logic [7:0] CODE_DDS_OFF = 8'h24;
	localparam logic [7:0] CODE_V54_UP = 8'hC7;
	localparam logic [7:0] CODE_V54_DN = 8'h39;
	localparam logic [7:0] CODE_FT1_UP = 8'h10;
	localparam logic [7:0] CODE_FT1_DN = 8'h12;
	localparam logic [7:0] CODE_PERF_UP = 8'hF0;
	localparam logic [7:0] CODE_PERF_DN = 8'h0F;
	typedef enum logic [1:0] {CTS_PERM, CTS_RLOCAL, CTS_IGNORE, CTS_LOCAL} sphl_cts_t;
	typedef enum logic [1:0] {NEAR_OFF, NEAR_DTE, NEAR_NET} sphl_near_t;
	typedef enum logic [1:0] {FMT_DDS, FMT_V54, FMT_FT1, FMT_PERF} sphl_fmt_t;
	typedef enum logic [2:0] {CMD_OFF, CMD_ON, CMD_OCU, CMD_DSU, CMD_CSU, CMD_DS0} sphl_cmd_t;
	typedef enum logic [1:0] {DET_OFF, DET_ON, DET_TIMED} sphl_det_t;
endpackage : sphl_pkg

// File: verilog/sphl_sync.sv
`timescale 1ns/1ps
module sphl_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Levels
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= '0;
			syncOut <= '0;
		end
		else
		begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule : sphl_sync

// File: tb/sphl_dte_model.sv
`timescale 1ns/1ps
module sphl_dte_model (
	// Bench control
	input wire logic rtsLevel,
	input wire logic clkRun,
	// Leads toward the port
	output logic dteRts,
	output logic dteSendData,
	output logic portClk
);
	logic [7:0] pattern_q = 8'hB5;
	initial
		portClk = 1'b0;
	assign dteRts = rtsLevel;
	// Link clock stands still between frames
	always #400
		portClk = clkRun ? ~portClk : 1'b0;
	// Data steps through an 8-bit pattern so a stuck loop shows
	always @(negedge portClk)
		pattern_q <= {pattern_q[6:0], pattern_q[7]};
	assign dteSendData = pattern_q[7];
endmodule : sphl_dte_model

// File: tb/tb_sphl_port.sv
`timescale 1ns/1ps
module tb_sphl_port
	import sphl_pkg::*;
;
	localparam int MS = 10;
	logic core_clk = 1'b0, rst = 1'b1, rts = 1'b0, clkRun = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, netRxCode = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, rd;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, netRxData = 1'b0, netRxCodeValid = 1'b0, errBit = 1'b0, seqGrant = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dteRts, dteSendData;
	logic portClk, dteCts, dteDsr, dteRecvData, dteRecvClk, netTxData, netRlsd, netTxCodeValid;
	logic perfTick, seqRequest, excessErrAlarm, remoteLoopActive;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata;
	logic [7:0] netTxCode;
	int n_errors = 0, compares = 0;
	always #50 core_clk = ~core_clk;
	sphl_port #(.MS_CNT(MS), .TIMEOUT_MS(5)) i_sphl_port (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dteRts, .dteSendData, .portClk, .dteCts, .dteDsr,
		.dteRecvData, .dteRecvClk, .netRxData, .netRemoteRts(1'b0), .netRxCode, .netRxCodeValid, .errBit,
		.netTxData, .netRlsd, .netTxCode, .netTxCodeValid, .perfTick, .seqGrant, .seqRequest,
		.excessErrAlarm, .remoteLoopActive);
	sphl_dte_model i_sphl_dte_model (.rtsLevel(rts), .clkRun, .dteRts, .dteSendData, .portClk);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (aw && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (w && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			aw = aw && s_axi_awready !== 1'b1;
			w = w && s_axi_wready !== 1'b1;
		end
		while (aw || w);
		do
			@(posedge core_clk);
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
	endtask : axiWrite
	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge core_clk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge core_clk);
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axiRead
	task automatic testReset();
		axiRead(REG_CTRL, rd, rs);
		check(rd, CTRL_RESET);
		axiRead(REG_LOOP, rd, rs);
		check(rd, LOOP_RESET);
		axiRead(REG_ERR, rd, rs);
		check(rd, ERR_RESET);
		check(dteCts, 1'b1);
		axiRead(8'h10, rd, rs);
		check(rs, 2'b10);
		check(rd, 32'h0);
		axiWrite(8'h10, 32'h1, 2'b10);
		$display("reset test done");
	endtask : testReset
	task automatic testCts();
		logic e;
		for (int i = 0; i < 8; i++)
		begin
			// Delay field set outside local mode must do nothing
			axiWrite(REG_CTRL, i[2:1] == 2'd3 ? 32'h3 : {28'h0, 2'b11, i[2:1]}, 2'b00);
			rts <= i[0];
			tick(6);
			e = i[2:1] == 2'd0 ? 1'b1 : i[2:1] == 2'd2 ? 1'b0 : i[0];
			check(dteCts, e);
			if (i[2:1] == 2'd1)
				check(netRlsd, i[0]);
			axiRead(REG_STATUS, rd, rs);
			check(rd[0], e);
		end
		$display("cts test done");
	endtask : testCts
	task automatic testDelay();
		int d;
		rts <= 1'b0;
		tick(1100);
		for (int c = 1; c < 4; c++)
		begin
			d = MS * (c == 1 ? CTS_DLY1_MS : c == 2 ? CTS_DLY2_MS : CTS_DLY3_MS);
			axiWrite(REG_CTRL, 32'h3 | (c << 2), 2'b00);
			for (int v = 1; v >= 0; v--)
			begin
				rts <= v[0];
				tick(d - 20);
				check(dteCts, !v[0]);
				tick(40);
				check(dteCts, v[0]);
			end
		end
		$display("delay test done");
	endtask : testDelay
	task automatic testClocks();
		clkRun <= 1'b1;
		for (int inv = 0; inv < 2; inv++)
		begin
			axiWrite(REG_CTRL, inv << 5, 2'b00);
			@(posedge portClk);
			tick(5);
			check(dteRecvClk, !inv[0]);
		end
		axiWrite(REG_CTRL, 32'h12, 2'b00);
		tick(6);
		check(dteCts, 1'b1);
		// Far loop in DTE role must not start a code sequence
		axiWrite(REG_LOOP, 32'h0000_0210, 2'b00);
		tick(2);
		check(seqRequest, 1'b0);
		$display("clock and role test done");
	endtask : testClocks
	task automatic testLoop();
		axiWrite(REG_LOOP, 32'h1, 2'b00);
		netRxData <= 1'b0;
		repeat (4)
		begin
			@(negedge portClk);
			tick(5);
			check(dteRecvData, dteSendData);
		end
		axiWrite(REG_CTRL, 32'h10, 2'b00);
		axiWrite(REG_LOOP, 32'h2, 2'b00);
		for (int b = 0; b < 4; b++)
		begin
			netRxData <= b[0];
			tick(8);
			check(netTxData, b[0]);
			check(dteDsr, 1'b0);
		end
		axiWrite(REG_CTRL, 32'h0, 2'b00);
		axiWrite(REG_LOOP, 32'h0, 2'b00);
		tick(4);
		check(dteDsr, 1'b1);
		$display("loopback test done");
	endtask : testLoop
	task automatic testCodes();
		logic [7:0] tbl [11] = '{CODE_DDS_OCU, CODE_DDS_DSU, CODE_DDS_CSU, CODE_DDS_DS0, CODE_DDS_OFF,
			CODE_V54_UP, CODE_V54_DN, CODE_FT1_UP, CODE_FT1_DN, CODE_PERF_UP, CODE_PERF_DN};
		logic [6:0] cfg [11] = '{7'h20, 7'h30, 7'h40, 7'h50, 7'h00, 7'h14, 7'h04, 7'h18, 7'h08, 7'h1C, 7'h0C};
		int cnt;
		for (int k = 0; k < 11; k++)
		begin
			axiWrite(REG_LOOP, {22'h0, 1'b1, 2'b10, cfg[k]}, 2'b00);
			cnt = 0;
			tick(30);
			check(seqRequest, 1'b1);
			check(netTxCodeValid, 1'b0);
			seqGrant <= 1'b1;
			repeat (100)
			begin
				@(posedge core_clk);
				if (netTxCodeValid === 1'b1)
				begin
					cnt++;
					check(netTxCode, tbl[k]);
				end
			end
			check(cnt, CODE_LEN);
			check(seqRequest, 1'b0);
			seqGrant <= 1'b0;
		end
		$display("code test done");
	endtask : testCodes
	task automatic sendCode(input logic [7:0] c, input logic e);
		netRxCode <= c;
		netRxCodeValid <= 1'b1;
		@(posedge core_clk);
		netRxCodeValid <= 1'b0;
		tick(6);
		check(remoteLoopActive, e);
	endtask : sendCode
	task automatic testDetect();
		axiWrite(REG_LOOP, 32'h84, 2'b00);
		sendCode(CODE_FT1_UP, 1'b0);
		sendCode(CODE_V54_UP, 1'b1);
		tick(200);
		check(remoteLoopActive, 1'b1);
		sendCode(CODE_V54_DN, 1'b0);
		axiWrite(REG_LOOP, 32'h04, 2'b00);
		sendCode(CODE_V54_UP, 1'b0);
		axiWrite(REG_LOOP, 32'h104, 2'b00);
		sendCode(CODE_V54_UP, 1'b1);
		tick(20);
		check(remoteLoopActive, 1'b1);
		tick(60);
		check(remoteLoopActive, 1'b0);
		$display("detect test done");
	endtask : testDetect
	task automatic testAlarm();
		for (int t = 0; t < 2; t++)
		begin
			// Short 17-bit window so the verdict comes soon
			axiWrite(REG_ERR, t ? 32'h0000_0104 : 32'h0000_0100, 2'b00);
			// Held across a port clock edge so each error is seen
			repeat (2)
			begin
				errBit <= 1'b1;
				tick(8);
				errBit <= 1'b0;
				tick(8);
			end
			// Past the window end, before the next one closes
			tick(150);
			check(excessErrAlarm, t[0]);
			axiRead(REG_STATUS, rd, rs);
			check(rd[1], t[0]);
		end
		$display("alarm test done");
	endtask : testAlarm
	task automatic testPerf();
		int cnt = 0;
		axiWrite(REG_LOOP, 32'h0C, 2'b00);
		repeat (10 * PERF_DIV)
		begin
			@(posedge core_clk);
			cnt += perfTick === 1'b1;
		end
		check(cnt >= 9 && cnt <= 11, 1'b1);
		axiWrite(REG_LOOP, 32'h0, 2'b00);
		cnt = 0;
		repeat (2 * PERF_DIV)
		begin
			@(posedge core_clk);
			cnt += perfTick === 1'b1;
		end
		check(cnt, 0);
		$display("perf test done");
	endtask : testPerf
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	initial
	begin
		tick(60000);
		n_errors++;
		summarize();
	end
	initial
	begin
		tick(6);
		rst <= 1'b0;
		tick(1);
		testReset();
		testCts();
		testDelay();
		testClocks();
		testLoop();
		testCodes();
		testDetect();
		testAlarm();
		testPerf();
		summarize();
	end
endmodule : tb_sphl_port
